// File: hw/atrd_map.svh
// Purpose: Opcode values, field positions and widths of the transfer decoder
// Assumes: 10-bit instruction words, 4-bit accumulator
// Notes:   Definitions only
`ifndef ATRD_MAP_SVH
`define ATRD_MAP_SVH
`define ATRD_OP_IRQ    10'h217
`define ATRD_OP_SER    10'h202
`define ATRD_OP_WAKE0  10'h21B
`define ATRD_OP_WAKE1  10'h214
`define ATRD_OP_WAKE2  10'h215
`define ATRD_OP_WAKEB  10'h20A
`define ATRD_OP_CLK    10'h216
`define ATRD_OP_STORE  6'h2B
`define ATRD_STORE_HI  9
`define ATRD_STORE_LO  4
`define ATRD_IMM_HI    3
`define ATRD_IMM_LO    0
`define ATRD_NIB_RST   4'h0
`endif

// File: hw/atrd_pkg.sv
// Purpose: Types shared by the transfer decoder
// Assumes: 4-bit data path, 10-bit words
// Notes:   Constants live in atrd_map.svh
package atrd_pkg;
  typedef logic [3:0] atrd_nib_t;   // One accumulator-wide nibble
  typedef logic [9:0] atrd_word_t;  // One instruction word
  // Decode result of one instruction word
  typedef struct packed {
    logic irq;
    logic ser;
    logic wake0;
    logic wake1;
    logic wake2;
    logic wakeb;
    logic clk;
    logic store;
  } atrd_dec_s;
  // Memory write request
  typedef struct packed {
    logic      we;
    atrd_nib_t data;
  } atrd_mem_s;
endpackage

// File: hw/atrd_decode.sv
// Purpose: Pure decode of a 10-bit word into transfer strobes
// Assumes: Word is stable for the whole instruction cycle
// Notes:   Registered state is one packed struct, idle state all zero
`timescale 1ns/1ps
`default_nettype none
`include "atrd_map.svh"
module atrd_decode
  import atrd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire atrd_word_t word,
  input  wire logic       valid,
  output atrd_dec_s       dec
);
  // State: only the latest decode
  typedef struct packed {
    atrd_dec_s dec;
  } atrd_dstate_s;
  atrd_dstate_s st_q;  // Registered decode
  atrd_dstate_s st_d;  // Next decode

  // Match an exact opcode; used for every full-word transfer
  function automatic logic hit(input atrd_word_t w, input atrd_word_t op);
    hit = (w == op);
  endfunction

  // Decode; only one strobe can be high since opcodes are distinct
  always_comb begin
    st_d           = '0;
    st_d.dec.irq   = valid & hit(word, `ATRD_OP_IRQ);
    st_d.dec.ser   = valid & hit(word, `ATRD_OP_SER);
    st_d.dec.wake0 = valid & hit(word, `ATRD_OP_WAKE0);
    st_d.dec.wake1 = valid & hit(word, `ATRD_OP_WAKE1);
    st_d.dec.wake2 = valid & hit(word, `ATRD_OP_WAKE2);
    st_d.dec.wakeb = valid & hit(word, `ATRD_OP_WAKEB);
    st_d.dec.clk   = valid & hit(word, `ATRD_OP_CLK);
    st_d.dec.store = valid & (word[`ATRD_STORE_HI:`ATRD_STORE_LO] == `ATRD_OP_STORE);
  end

  // Register the decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dec = st_q.dec;
endmodule
`default_nettype wire

// File: hw/atrd_top.sv
// Purpose: Execute accumulator-transfer instructions into control registers
// Assumes: One instruction per MCLK cycle when INSTR_VALID is high
// Notes:   Two-stage: decode register, then write stage; fully pipelined
`timescale 1ns/1ps
`default_nettype none
`include "atrd_map.svh"
// Function
// - 0x217 copies accumulator to interrupt control
// - 0x202 copies accumulator to serial control
// - 0x21B copies accumulator to wake control zero
// - 0x214 copies accumulator to wake control one
// - 0x215 copies accumulator to wake control two
// - 0x20A copies accumulator to wake control B
// - 0x2B-prefix stores accumulator at data pointer
// - Then X pointer becomes X OR immediate
// - 0x216 copies accumulator to clock control
module atrd_top
  import atrd_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  input  wire atrd_word_t INSTR,
  input  wire logic       INSTR_VALID,
  input  wire atrd_nib_t  ACC,
  input  wire atrd_nib_t  DATA_POINTER,
  output atrd_nib_t       IRQ_CTRL_REG,
  output atrd_nib_t       SERIAL_CTRL_REG,
  output atrd_nib_t       WAKE_CTRL_REG0,
  output atrd_nib_t       WAKE_CTRL_REG1,
  output atrd_nib_t       WAKE_CTRL_REG2,
  output atrd_nib_t       WAKE_CTRL_REG_B,
  output atrd_nib_t       CLOCK_CTRL_REG,
  output atrd_nib_t       XPTR,
  output logic            MEM_WE,
  output atrd_nib_t       MEM_ADDR,
  output atrd_nib_t       MEM_WDATA,
  output logic            CARRY_WE,
  output logic            SKIP_NEXT
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic rst_s1_q;  // First stage, read only by second
  logic rst_s2_q;  // Released reset used everywhere else

  // Release reset cleanly on MCLK to avoid partial-state starts
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode stage

  atrd_dec_s dec;  // Registered decode strobes

  // Operands are held alongside the decode so the write stage is aligned
  typedef struct packed {
    atrd_nib_t acc;   // Accumulator captured with the word
    atrd_nib_t dptr;  // Data pointer captured with the word
    atrd_nib_t imm;   // Immediate field of the store form
    atrd_nib_t irq;
    atrd_nib_t ser;
    atrd_nib_t wake0;
    atrd_nib_t wake1;
    atrd_nib_t wake2;
    atrd_nib_t wakeb;
    atrd_nib_t clk;
    atrd_nib_t xptr;
    atrd_mem_s mem;
    atrd_nib_t maddr;
    logic      carry_we;
    logic      skip;
  } atrd_state_s;

  atrd_state_s st_q;  // Registered state
  atrd_state_s st_d;  // Next state

  atrd_decode u_dec (
    .clk   (MCLK),
    .rst_n (rst_s2_q),
    .word  (INSTR),
    .valid (INSTR_VALID),
    .dec   (dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write stage

  // Targets hold unless their strobe fires; the store pulses one cycle
  always_comb begin
    st_d        = st_q;
    st_d.acc    = ACC;
    st_d.dptr   = DATA_POINTER;
    st_d.imm    = INSTR[`ATRD_IMM_HI:`ATRD_IMM_LO];
    st_d.mem.we = 1'b0;
    // This group never touches carry or skip
    st_d.carry_we = 1'b0;
    st_d.skip   = 1'b0;
    if (dec.irq) begin
      st_d.irq = st_q.acc;
    end
    if (dec.ser) begin
      st_d.ser = st_q.acc;
    end
    if (dec.wake0) begin
      st_d.wake0 = st_q.acc;
    end
    if (dec.wake1) begin
      st_d.wake1 = st_q.acc;
    end
    if (dec.wake2) begin
      st_d.wake2 = st_q.acc;
    end
    if (dec.wakeb) begin
      st_d.wakeb = st_q.acc;
    end
    if (dec.clk) begin
      st_d.clk = st_q.acc;
    end
    if (dec.store) begin
      // Memory write and pointer update land in the same cycle
      st_d.mem.we   = 1'b1;
      st_d.mem.data = st_q.acc;
      st_d.maddr    = st_q.dptr;
      st_d.xptr     = st_q.xptr | st_q.imm;
    end
  end

  // Register all state
  always_ff @(posedge MCLK or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign IRQ_CTRL_REG    = st_q.irq;
  assign SERIAL_CTRL_REG = st_q.ser;
  assign WAKE_CTRL_REG0  = st_q.wake0;
  assign WAKE_CTRL_REG1  = st_q.wake1;
  assign WAKE_CTRL_REG2  = st_q.wake2;
  assign WAKE_CTRL_REG_B = st_q.wakeb;
  assign CLOCK_CTRL_REG  = st_q.clk;
  assign XPTR            = st_q.xptr;
  assign MEM_WE          = st_q.mem.we;
  assign MEM_ADDR        = st_q.maddr;
  assign MEM_WDATA       = st_q.mem.data;
  assign CARRY_WE        = st_q.carry_we;
  assign SKIP_NEXT       = st_q.skip;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Word presented with valid, then acted on two edges later
  sequence s_word(atrd_word_t w);
    INSTR_VALID && INSTR == w;
  endsequence

  irq_copy_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_word(`ATRD_OP_IRQ) |-> ##2 IRQ_CTRL_REG == $past(ACC, 2))
    else $error("interrupt control not loaded");
  ser_copy_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_word(`ATRD_OP_SER) |-> ##2 SERIAL_CTRL_REG == $past(ACC, 2))
    else $error("serial control not loaded");
  wake0_copy_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_word(`ATRD_OP_WAKE0) |-> ##2 WAKE_CTRL_REG0 == $past(ACC, 2))
    else $error("wake control zero not loaded");
  wake1_copy_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_word(`ATRD_OP_WAKE1) |-> ##2 WAKE_CTRL_REG1 == $past(ACC, 2))
    else $error("wake control one not loaded");
  wake2_copy_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_word(`ATRD_OP_WAKE2) |-> ##2 WAKE_CTRL_REG2 == $past(ACC, 2))
    else $error("wake control two not loaded");
  wakeb_copy_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_word(`ATRD_OP_WAKEB) |-> ##2 WAKE_CTRL_REG_B == $past(ACC, 2))
    else $error("wake control B not loaded");
  clk_copy_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_word(`ATRD_OP_CLK) |-> ##2 CLOCK_CTRL_REG == $past(ACC, 2))
    else $error("clock control not loaded");
  store_mem_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    INSTR_VALID && INSTR[`ATRD_STORE_HI:`ATRD_STORE_LO] == `ATRD_OP_STORE
    |-> ##2 MEM_WE && MEM_WDATA == $past(ACC, 2) && MEM_ADDR == $past(DATA_POINTER, 2))
    else $error("store did not write memory");
  xptr_or_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    MEM_WE |-> XPTR == ($past(XPTR) | $past(INSTR[`ATRD_IMM_HI:`ATRD_IMM_LO], 2)))
    else $error("X pointer not ORed");
  no_flag_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    !CARRY_WE && !SKIP_NEXT)
    else $error("carry or skip touched");

  // Any word but the given transfer; its target must then keep its value,
  // which catches a decode that fires on neighbouring opcodes
  sequence s_not_word(atrd_word_t w);
    !(INSTR_VALID && INSTR == w);
  endsequence

  irq_hold_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_not_word(`ATRD_OP_IRQ) |-> ##2 $stable(IRQ_CTRL_REG))
    else $error("interrupt control changed unasked");
  ser_hold_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_not_word(`ATRD_OP_SER) |-> ##2 $stable(SERIAL_CTRL_REG))
    else $error("serial control changed unasked");
  wake0_hold_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_not_word(`ATRD_OP_WAKE0) |-> ##2 $stable(WAKE_CTRL_REG0))
    else $error("wake control zero changed unasked");
  wake1_hold_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_not_word(`ATRD_OP_WAKE1) |-> ##2 $stable(WAKE_CTRL_REG1))
    else $error("wake control one changed unasked");
  wake2_hold_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_not_word(`ATRD_OP_WAKE2) |-> ##2 $stable(WAKE_CTRL_REG2))
    else $error("wake control two changed unasked");
  wakeb_hold_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_not_word(`ATRD_OP_WAKEB) |-> ##2 $stable(WAKE_CTRL_REG_B))
    else $error("wake control B changed unasked");
  clk_hold_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    s_not_word(`ATRD_OP_CLK) |-> ##2 $stable(CLOCK_CTRL_REG))
    else $error("clock control changed unasked");
  // A write pulse may only come from a qualified store word
  store_only_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    MEM_WE |-> $past(INSTR_VALID, 2)
               && $past(INSTR[`ATRD_STORE_HI:`ATRD_STORE_LO], 2) == `ATRD_OP_STORE)
    else $error("memory write without store");
  // The X pointer moves only together with a store
  xptr_hold_a: assert property (@(posedge MCLK) disable iff (!rst_s2_q)
    !MEM_WE |-> $stable(XPTR))
    else $error("X pointer changed without store");
endmodule
`default_nettype wire

// File: test/atrd_top_bench.sv
// Purpose: Self-checking bench for the accumulator transfer decoder
// Assumes: Result visible one edge after the taking edge
// Notes:   Inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module atrd_top_bench
  import atrd_pkg::*;
;
  logic        MCLK = 1'b0;          // 250 MHz core clock
  logic        RST_N = 1'b0;         // Held low at start
  atrd_word_t  INSTR = 10'h000;      // Instruction word
  logic        INSTR_VALID = 1'b0;   // Word qualifier
  atrd_nib_t   ACC = 4'h0;           // Accumulator
  atrd_nib_t   DATA_POINTER = 4'h0;  // Store address
  atrd_nib_t   IRQ_CTRL_REG, SERIAL_CTRL_REG, WAKE_CTRL_REG0, WAKE_CTRL_REG1;
  atrd_nib_t   WAKE_CTRL_REG2, WAKE_CTRL_REG_B, CLOCK_CTRL_REG, XPTR, MEM_ADDR, MEM_WDATA;
  logic        MEM_WE, CARRY_WE, SKIP_NEXT;
  int          num_errors = 0;       // Mismatches
  int          checks_done = 0;      // Comparisons
  atrd_nib_t   exp_regs [7];         // Expected control registers
  atrd_nib_t   xptr_exp;             // Expected X pointer
  logic [11:0] wr_log [$];           // Seen stores: addr, data, X
  logic [27:0] regs_w;               // Control registers side by side
  // Opcodes in output order; a table keeps the sweep short
  localparam atrd_word_t OPS [7] = '{10'h217, 10'h202, 10'h21B, 10'h214, 10'h215, 10'h20A, 10'h216};
  localparam atrd_nib_t  IMMS [5] = '{4'h1, 4'h4, 4'h0, 4'h8, 4'hF};

  assign regs_w = {CLOCK_CTRL_REG, WAKE_CTRL_REG_B, WAKE_CTRL_REG2, WAKE_CTRL_REG1,
                   WAKE_CTRL_REG0, SERIAL_CTRL_REG, IRQ_CTRL_REG};

  atrd_top DUT (.MCLK(MCLK), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
    .ACC(ACC), .DATA_POINTER(DATA_POINTER), .IRQ_CTRL_REG(IRQ_CTRL_REG),
    .SERIAL_CTRL_REG(SERIAL_CTRL_REG), .WAKE_CTRL_REG0(WAKE_CTRL_REG0),
    .WAKE_CTRL_REG1(WAKE_CTRL_REG1), .WAKE_CTRL_REG2(WAKE_CTRL_REG2),
    .WAKE_CTRL_REG_B(WAKE_CTRL_REG_B), .CLOCK_CTRL_REG(CLOCK_CTRL_REG), .XPTR(XPTR),
    .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .CARRY_WE(CARRY_WE),
    .SKIP_NEXT(SKIP_NEXT));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  always #2 MCLK = ~MCLK;

  // Log stores on the falling edge, away from the update edge
  always @(negedge MCLK) begin
    if (MEM_WE === 1'b1) begin
      wr_log.push_back({MEM_ADDR, MEM_WDATA, XPTR});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One comparison, counted
  task automatic chk(input logic [11:0] got, input logic [11:0] want, input string what);
    checks_done++;
    if (got !== want) begin
      num_errors++;
      $display("[FAIL] %0t ns: %s got %h want %h", $time, what, got, want);
    end
  endtask

  // Present one word for one cycle; returns just after the taking edge
  task automatic send(input atrd_word_t w, input atrd_nib_t a, input atrd_nib_t d, input logic v);
    INSTR = w;
    INSTR_VALID = v;
    ACC = a;
    DATA_POINTER = d;
    @(posedge MCLK);
    #1;
  endtask

  // Drop the qualifier and let n edges pass
  task automatic idle(input int n);
    INSTR_VALID = 1'b0;
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  // All control registers, plus flags that must stay quiet
  task automatic chk_all();
    for (int i = 0; i < 7; i++) begin
      chk({8'h00, regs_w[i*4 +: 4]}, {8'h00, exp_regs[i]}, "control register");
    end
    chk({11'h000, CARRY_WE}, 12'h000, "carry write");
    chk({11'h000, SKIP_NEXT}, 12'h000, "skip request");
    chk({8'h00, XPTR}, {8'h00, xptr_exp}, "X pointer");
  endtask

  // Verdict, shared by the tests and the watchdog
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    foreach (exp_regs[i]) exp_regs[i] = 4'h0;
    xptr_exp = 4'h0;
    repeat (2) @(posedge MCLK);
    #1;
    RST_N = 1'b1;
    idle(4);
    chk_all(); // Quiet after reset
    $display("Test reset done");
    // Each opcode lands in its own register only, one cycle
    for (int i = 0; i < 7; i++) begin
      send(OPS[i], 4'(i + 9), 4'h0, 1'b1);
      idle(2);
      exp_regs[i] = 4'(i + 9);
      chk_all(); // Single target written
    end
    $display("Test opcode sweep done");
    // Back to back, then an unqualified word, an unknown word and a near-store word
    send(OPS[0], 4'h5, 4'h0, 1'b1);
    send(OPS[6], 4'h6, 4'h0, 1'b1);
    send(OPS[1], 4'h3, 4'h0, 1'b0);
    send(10'h218, 4'hE, 4'h0, 1'b1);
    send(10'h2C3, 4'hD, 4'h1, 1'b1);
    idle(2);
    exp_regs[0] = 4'h5;
    exp_regs[6] = 4'h6;
    chk_all(); // Pipelined pair lands
    chk(12'(wr_log.size()), 12'h000, "stray store"); // No store yet
    $display("Test back to back done");
    // Stores back to back, immediates include both ends of the range
    for (int k = 0; k < 5; k++) begin
      send({6'h2B, IMMS[k]}, 4'(k + 2), 4'(12 - k), 1'b1);
    end
    idle(3);
    chk(12'(wr_log.size()), 12'h005, "store pulse count"); // One pulse each
    for (int k = 0; k < 5; k++) begin
      xptr_exp = xptr_exp | IMMS[k];
      chk(wr_log[k], {4'(12 - k), 4'(k + 2), xptr_exp}, "store entry");
    end
    chk_all(); // Stores leave control registers alone
    $display("Test store done");
    // Reset in mid-run clears every register and the X pointer
    RST_N = 1'b0;
    idle(2);
    RST_N = 1'b1;
    idle(4);
    foreach (exp_regs[i]) exp_regs[i] = 4'h0;
    send({6'h2B, 4'h6}, 4'hA, 4'h7, 1'b1);
    idle(3);
    xptr_exp = 4'h6;
    chk(12'(wr_log.size()), 12'h006, "store after reset");
    chk(wr_log[5], 12'h7A6, "store entry after reset");
    chk_all(); // Cleared, then ORed from zero
    $display("Test mid-run reset done");
    finish_test();
  end

  // Watchdog: the tests need well under 200 cycles
  initial begin
    #4000;
    num_errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
